// ===== vchl_params.svh
// register offsets, field positions, reset values and timing counts of the channel bank
`ifndef VCHL_PARAMS_SVH
`define VCHL_PARAMS_SVH
`define VCHL_HDR_LOG0_OFF 12'h11C
`define VCHL_HDR_LOG1_OFF 12'h120
`define VCHL_HDR_LOG2_OFF 12'h124
`define VCHL_HDR_LOG3_OFF 12'h128
`define VCHL_CAP_HDR_OFF 12'h140
`define VCHL_CAP_ONE_OFF 12'h144
`define VCHL_CAP_TWO_OFF 12'h148
`define VCHL_CTL_STAT_OFF 12'h14C
`define VCHL_TABLE_BASE_OFF 12'h170
`define VCHL_TABLE_LAST_OFF 12'h17C
`define VCHL_OVR_OFF 12'h200
`define VCHL_EXT_CAP_ID 16'h0002
`define VCHL_CAP_VERSION 4'h1
`define VCHL_NEXT_CAP_PTR 12'h20C
`define VCHL_REF_CLK_100NS 2'h0
`define VCHL_ENTRY_SIZE_4BIT 2'h2
`define VCHL_ARB_CAP_ONE 8'h03
`define VCHL_ARB_CAP_NONE 8'h00
`define VCHL_TABLE_LOC_ONE 8'h03
`define VCHL_TABLE_LOC_NONE 8'h00
`define VCHL_COUNT_RESET 3'h0
`define VCHL_SEL_RESET 3'h0
`define VCHL_LOAD_BIT 0
`define VCHL_SEL_LSB 1
`define VCHL_STATUS_BIT 16
`define VCHL_LOAD_CYCLES 4
`endif

// ===== vchl_pkg.sv
// types of the channel bank
package vchl_pkg;
    typedef struct packed {
        logic [11:0] next_ptr;
        logic [3:0] version;
        logic [15:0] cap_id;
    } vchl_cap_hdr_type;
    typedef struct packed {
        logic [19:0] rsvd_hi;
        logic [1:0] entry_size;
        logic [1:0] ref_clk;
        logic rsvd_7;
        logic [2:0] low_priority_channel_group;
        logic rsvd_3;
        logic [2:0] ext_count;
    } vchl_cap_one_type;
    typedef struct packed {
        logic [7:0] table_loc;
        logic [15:0] rsvd;
        logic [7:0] arb_cap;
    } vchl_cap_two_type;
    typedef enum logic [1:0] {
        VCHL_IDLE = 2'b00,
        VCHL_LOAD = 2'b01
    } vchl_load_state_type;
endpackage

// ===== vchl_regs.sv
// channel capability and header log register bank behind an ahb-lite slave
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
`include "vchl_params.svh"

module vchl_regs #(
    parameter int TABLE_WORDS = 4,
    parameter int LOAD_CYCLES = `VCHL_LOAD_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic hdr_log_valid,
    input wire logic [127:0] hdr_log_bytes,
    input wire logic count_override_valid,
    input wire logic [2:0] ext_count_in,
    input wire logic [2:0] low_priority_channel_group_in,
    output logic [31:0] active_table [TABLE_WORDS],
    output logic [2:0] active_scheme,
    output logic table_load_done
);
    // ========================================
    // ahb address phase capture
    logic wr_pend_q;
    logic rd_pend_q;
    logic [11:0] addr_q;
    logic [11:0] off;
    wire addr_ok = hsel & hready & htrans[1];
    assign off = addr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            rd_pend_q <= addr_ok & ~hwrite;
            if (addr_ok) begin
                addr_q <= {haddr[11:2], 2'b00};
            end
        end
    end

    // ========================================
    // state registers
    logic [31:0] hdr_q [4];
    logic [2:0] ext_count_q;
    logic [2:0] lpg_q;
    logic [2:0] sel_q;
    logic status_q;
    logic [31:0] table_q [TABLE_WORDS];
    logic [31:0] act_q [TABLE_WORDS];
    logic [2:0] act_sel_q;
    logic done_q;
    logic [15:0] cnt_q;
    vchl_pkg::vchl_load_state_type st_q;

    wire wr_ctl = wr_pend_q & (off == `VCHL_CTL_STAT_OFF);
    wire wr_ovr = wr_pend_q & (off == `VCHL_OVR_OFF);
    wire in_table = (off >= `VCHL_TABLE_BASE_OFF) & (off <= `VCHL_TABLE_LAST_OFF);
    wire wr_table = wr_pend_q & in_table;
    wire [1:0] tidx = off[3:2];
    wire load_req = wr_ctl & hwdata[`VCHL_LOAD_BIT];
    wire load_end = (st_q == vchl_pkg::VCHL_LOAD) & (cnt_q == 16'h0000);
    wire [2:0] sel_wr = hwdata[`VCHL_SEL_LSB +: 3];
    wire sel_valid = (sel_wr == 3'h0) | (sel_wr == 3'h1);

    // header log, first byte to top byte of each word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                hdr_q[i] <= 32'h00000000;
            end
        end else if (hdr_log_valid) begin
            for (int i = 0; i < 4; i++) begin
                hdr_q[i] <= hdr_log_bytes[127 - 32 * i -: 32];
            end
        end
    end

    // channel counts, overridable by sideband loader or software port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_count_q <= `VCHL_COUNT_RESET;
            lpg_q <= `VCHL_COUNT_RESET;
        end else if (count_override_valid) begin
            ext_count_q <= ext_count_in;
            lpg_q <= low_priority_channel_group_in;
        end else if (wr_ovr) begin
            ext_count_q <= hwdata[2:0];
            lpg_q <= hwdata[6:4];
        end
    end

    // scheme selector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= `VCHL_SEL_RESET;
        end else if (wr_ctl) begin
            sel_q <= sel_valid ? sel_wr : `VCHL_SEL_RESET;
        end
    end

    // programmed table entries
    generate
        for (genvar g = 0; g < TABLE_WORDS; g++) begin : g_tab
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    table_q[g] <= 32'h00000000;
                    act_q[g] <= 32'h00000000;
                end else begin
                    if (wr_table & (tidx == 2'(g))) begin
                        table_q[g] <= hwdata;
                    end
                    if (load_end) begin
                        act_q[g] <= table_q[g];
                    end
                end
            end
            assign active_table[g] = act_q[g];
        end
    endgenerate

    // load sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= vchl_pkg::VCHL_IDLE;
            cnt_q <= 16'h0000;
            act_sel_q <= 3'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= load_end;
            case (st_q)
                vchl_pkg::VCHL_IDLE: begin
                    if (load_req) begin
                        st_q <= vchl_pkg::VCHL_LOAD;
                        cnt_q <= 16'(LOAD_CYCLES - 1);
                    end
                end
                vchl_pkg::VCHL_LOAD: begin
                    if (load_end) begin
                        st_q <= vchl_pkg::VCHL_IDLE;
                        act_sel_q <= sel_q;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    st_q <= vchl_pkg::VCHL_IDLE;
                end
            endcase
        end
    end

    // status flag: a table write in the same cycle wins over load completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= 1'b0;
        end else if (wr_table) begin
            status_q <= 1'b1;
        end else if (load_end) begin
            status_q <= 1'b0;
        end
    end

    assign active_scheme = act_sel_q;
    assign table_load_done = done_q;

    // ========================================
    // read view
    vchl_pkg::vchl_cap_hdr_type cap_hdr;
    vchl_pkg::vchl_cap_one_type cap_one;
    vchl_pkg::vchl_cap_two_type cap_two;
    wire one_ext = (ext_count_q == 3'h1);
    wire lpg_nz = (lpg_q != 3'h0);

    assign cap_hdr.cap_id = `VCHL_EXT_CAP_ID;
    assign cap_hdr.version = `VCHL_CAP_VERSION;
    assign cap_hdr.next_ptr = `VCHL_NEXT_CAP_PTR;
    assign cap_one.rsvd_hi = 20'h00000;
    assign cap_one.entry_size = `VCHL_ENTRY_SIZE_4BIT;
    assign cap_one.ref_clk = `VCHL_REF_CLK_100NS;
    assign cap_one.rsvd_7 = 1'b0;
    assign cap_one.low_priority_channel_group = lpg_q;
    assign cap_one.rsvd_3 = 1'b0;
    assign cap_one.ext_count = ext_count_q;
    // capability is reported as documented; it follows ext_count alone and the group count (lpg_nz) drives nothing
    assign cap_two.arb_cap = one_ext ? `VCHL_ARB_CAP_ONE : `VCHL_ARB_CAP_NONE;
    assign cap_two.rsvd = 16'h0000;
    assign cap_two.table_loc = one_ext ? `VCHL_TABLE_LOC_ONE : `VCHL_TABLE_LOC_NONE;
    wire unused_lpg = lpg_nz;

    // load bit reads zero, status in bit 16
    wire [31:0] ctl_word = {15'h0000, status_q, 12'h000, sel_q, 1'b0};
    wire [31:0] ovr_word = {25'h0000000, lpg_q, 1'b0, ext_count_q};

    // read decode works on the address phase so hrdata is registered into the data phase;
    // a read issued in the data phase of a write sees the value from before that write
    wire [11:0] look_off = {haddr[11:2], 2'b00};
    wire look_table = (look_off >= `VCHL_TABLE_BASE_OFF) & (look_off <= `VCHL_TABLE_LAST_OFF);
    wire [1:0] look_idx = look_off[3:2];

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (look_off)
            `VCHL_HDR_LOG0_OFF: rd_mux = hdr_q[0];
            `VCHL_HDR_LOG1_OFF: rd_mux = hdr_q[1];
            `VCHL_HDR_LOG2_OFF: rd_mux = hdr_q[2];
            `VCHL_HDR_LOG3_OFF: rd_mux = hdr_q[3];
            `VCHL_CAP_HDR_OFF: rd_mux = cap_hdr;
            `VCHL_CAP_ONE_OFF: rd_mux = cap_one;
            `VCHL_CAP_TWO_OFF: rd_mux = cap_two;
            `VCHL_CTL_STAT_OFF: rd_mux = ctl_word;
            `VCHL_OVR_OFF: rd_mux = ovr_word;
            default: begin
                if (look_table) begin
                    rd_mux = table_q[look_idx];
                end
            end
        endcase
    end

    // ========================================
    // data phase answer: zero wait, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ok & ~hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end
endmodule

// ===== vchl_regs_properties.sv
// assertions on the ports of the channel bank
`timescale 1ns/10ps
module vchl_regs_properties #(
    parameter int LOAD_CYCLES = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic hdr_log_valid,
    input wire logic [127:0] hdr_log_bytes,
    input wire logic count_override_valid,
    input wire logic [2:0] ext_count_in,
    input wire logic [2:0] low_priority_channel_group_in,
    input wire logic [2:0] active_scheme,
    input wire logic table_load_done
);
    // ====
    // shadow of read address and sideband values
    logic rd_q;
    logic [31:0] ra_q;
    logic [127:0] log_q;
    logic [2:0] ext_q;
    logic [2:0] grp_q;
    wire take = hsel && hready && htrans[1];
    wire [1:0] li = ra_q[3:2] - 2'h3;
    wire in_log = ra_q >= 32'h11C && ra_q <= 32'h128 && ra_q[1:0] == 2'h0;
    wire [31:0] log_word = log_q[(3 - li) * 32 +: 32];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'h0;
            ra_q <= 32'h0;
            log_q <= 128'h0;
            ext_q <= 3'h0;
            grp_q <= 3'h0;
        end else begin
            rd_q <= take && !hwrite;
            ra_q <= haddr;
            if (hdr_log_valid)
                log_q <= hdr_log_bytes;
            if (count_override_valid) begin
                ext_q <= ext_count_in;
                grp_q <= low_priority_channel_group_in;
            end
        end
    end
    // ====
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("slave not ready or not okay");
    property p_cap_hdr; rd_q && ra_q == 32'h140 |-> hrdata == 32'h20C10002; endproperty
    a_cap_hdr: assert property (p_cap_hdr) else $error("bad cap header");
    property p_cap_one;
        rd_q && ra_q == 32'h144 |-> hrdata == {20'h0, 4'h8, 1'h0, grp_q, 1'h0, ext_q};
    endproperty
    a_cap_one: assert property (p_cap_one) else $error("bad cap one");
    property p_cap_two;
        rd_q && ra_q == 32'h148 |-> hrdata == (ext_q == 3'h1 ? 32'h03000003 : 32'h0);
    endproperty
    a_cap_two: assert property (p_cap_two) else $error("bad cap two");
    property p_ctl;
        rd_q && ra_q == 32'h14C |-> !hrdata[0] && hrdata[15:4] == 12'h0 && hrdata[31:17] == 15'h0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("bad control read");
    property p_log; rd_q && in_log |-> hrdata == log_word; endproperty
    a_log: assert property (p_log) else $error("bad header word");
    property p_load; take && hwrite && haddr == 32'h14C ##1 hwdata[0] |-> ##[1:8] table_load_done;
    endproperty
    a_load: assert property (p_load) else $error("load never done");
    property p_scheme; active_scheme <= 3'h1; endproperty
    a_scheme: assert property (p_scheme) else $error("bad scheme");
    c_load: cover property (table_load_done);
    c_log: cover property (rd_q && in_log);
    c_ovr: cover property (count_override_valid && ext_count_in == 3'h1);
endmodule

bind vchl_regs vchl_regs_properties #(.LOAD_CYCLES(LOAD_CYCLES)) u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .hdr_log_valid, .hdr_log_bytes, .count_override_valid, .ext_count_in,
    .low_priority_channel_group_in, .active_scheme, .table_load_done
);

// ===== test_channel_cap_header_header_log_regs.sv
// self-checking bench of the channel bank
`timescale 1ns/10ps
module test_channel_cap_header_header_log_regs;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] e;
    } vchl_row_type;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic hdr_log_valid = 1'h0, count_override_valid = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, ext_count_in = 3'h0, low_priority_channel_group_in = 3'h0;
    logic [2:0] active_scheme;
    logic [127:0] hdr_log_bytes = 128'h0;
    logic hready, hresp, table_load_done;
    logic [31:0] active_table [4];
    int err_total = 0, checks_done = 0, cyc = 0, n;
    vchl_row_type rows [5] = '{
        '{32'h140, 32'h20C10002},
        '{32'h144, 32'h00000800},
        '{32'h148, 32'h00000000},
        '{32'h14C, 32'h00000000},
        '{32'h300, 32'h00000000}
    };
    vchl_regs #(.TABLE_WORDS(4), .LOAD_CYCLES(4)) u_vchl_regs (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout(hready), .hresp, .hrdata, .hdr_log_valid, .hdr_log_bytes,
        .count_override_valid, .ext_count_in, .low_priority_channel_group_in,
        .active_table, .active_scheme, .table_load_done
    );
    always #20 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // ====
    // one single transfer, answer taken at the falling edge with hready high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        logic ok;
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do begin
            @(negedge hclk);
            ok = hready;
            @(posedge hclk);
        end while (!ok);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge hclk);
            ok = hready;
            r = hrdata;
            @(posedge hclk);
        end while (!ok);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(r, e);
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        foreach (rows[i])
            rd(rows[i].a, rows[i].e);
        hdr_log_bytes <= 128'h00112233445566778899AABBCCDDEEFF;
        hdr_log_valid <= 1'h1;
        @(posedge hclk);
        hdr_log_valid <= 1'h0;
        bus(1'h1, 32'h11C, 32'h0);
        for (int i = 0; i < 4; i++)
            rd(32'h11C + 4 * i, 32'h00112233 + 32'h44444444 * i);
        ext_count_in <= 3'h1;
        low_priority_channel_group_in <= 3'h3;
        count_override_valid <= 1'h1;
        @(posedge hclk);
        count_override_valid <= 1'h0;
        rd(32'h144, 32'h00000831);
        rd(32'h148, 32'h03000003);
        bus(1'h1, 32'h14C, 32'hFFFEFFF2);
        rd(32'h14C, 32'h00000002);
        bus(1'h1, 32'h14C, 32'h0000000A);
        rd(32'h14C, 32'h00000000);
        for (int i = 0; i < 4; i++)
            bus(1'h1, 32'h170 + 4 * i, 32'hA5000000 + i);
        rd(32'h14C, 32'h00010000);
        bus(1'h1, 32'h14C, 32'h00000003);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (table_load_done !== 1'h1 && n < 20);
        chk({31'h0, table_load_done}, 32'h1);
        @(posedge hclk);
        foreach (active_table[i])
            chk(active_table[i], 32'hA5000000 + i);
        chk({29'h0, active_scheme}, 32'h1);
        rd(32'h14C, 32'h00000002);
        hresetn <= 1'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rd(32'h144, 32'h00000800);
        rd(32'h11C, 32'h00000000);
        tally_and_finish();
    end
endmodule
